// file: rtl/sfp_guard.sv
// Purpose: Command guard and write protection for a 128Mb serial flash array
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Erase walks one byte per clock; bulk erase is long
//
// How it works
// [R01] Program only clears bits, never sets
// [R02] Erase returns every byte to all ones
// [R03] Erase by subsector, sector or whole array
// [R04] Array of 16M bytes, 256 sectors
// [R05] Separate 64-byte one-time area
// [R06] Refuse modify unless whole bytes clocked
// [R07] Modify needs write enable latch set
// [R08] No data change until power-up timer expires
// [R09] Sector write-lock bit blocks program and erase
// [R10] Lock-down freezes sector lock until reset
// [R11] Lock write ignored while lock-down set
// [R12] All sectors locked after reset
// [R13] Top select: code n guards top sectors
// [R14] Bottom select: code n guards low sectors
// [R15] Write-protect pin holds block-protect area; quad mode ignores the pin
// [R16] Sector from bits 23:16, subsector 23:12
// [R17] Protected target leaves contents unchanged

`timescale 1ns/1ps
`default_nettype none

module sfp_guard (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic wp_b_in,
  input wire logic quad_mode_in,
  output logic [31:0] rdata_out,
  output logic busy_out
);

  typedef struct packed {
    sfp_pkg::sfp_state_e state;
    logic [sfp_pkg::SECTORS-1:0] write_lock;
    logic [sfp_pkg::SECTORS-1:0] lock_down;
    logic wel;
    logic [3:0] block_protect_bits;
    logic top_bottom_select;
    logic [23:0] addr;
    logic [7:0] data;
    logic [23:0] cursor;
    logic [23:0] last;
    logic [7:0] rd_byte;
    logic rd_otp;
    logic refused;
    logic [15:0] por_cnt;
    logic por_done;
    logic [31:0] rdata;
    logic busy;
  } sfp_guard_s;

  // ***********************************************
  // Decoding helpers
  // ***********************************************
  // Commands that change array or register contents
  function automatic logic is_modify(input sfp_pkg::sfp_cmd_e op);
    return op inside {sfp_pkg::CMD_PROGRAM, sfp_pkg::CMD_SUB_ERASE,
      sfp_pkg::CMD_SEC_ERASE, sfp_pkg::CMD_BULK_ERASE, sfp_pkg::CMD_WR_STATUS,
      sfp_pkg::CMD_WR_LOCK, sfp_pkg::CMD_OTP_PROGRAM};
  endfunction

  // Block-protect area test for one sector
  function automatic logic bp_hit(input logic [3:0] code, input logic tb,
                                  input logic [7:0] sec);
    logic [8:0] span;
    logic hit;
    span = 9'h001 << (code - 4'h1);
    if (code == 4'h0) begin
      hit = 1'b0;
    end else if (code > 4'h8) begin
      hit = 1'b1; // [R13] [R14]
    end else if (tb) begin
      hit = {1'b0, sec} < span; // [R14]
    end else begin
      hit = {1'b0, sec} >= (9'h100 - span); // [R13]
    end
    return hit;
  endfunction

  sfp_guard_s s, next_s;
  logic arr_we;
  logic arr_and;
  logic arr_otp;
  logic [23:0] arr_addr;
  logic [7:0] arr_wdata;
  logic [7:0] arr_rdata;
  logic [7:0] sec;
  logic cmd_wr;
  sfp_pkg::sfp_cmd_e op;
  logic [15:0] clk_count;

  assign sec = s.addr[23:sfp_pkg::SEC_LSB]; // [R16]
  assign cmd_wr = wr_in && (addr_in == sfp_pkg::REG_CMD);
  assign op = sfp_pkg::sfp_cmd_e'(wdata_in[3:0]);
  assign clk_count = wdata_in[31:sfp_pkg::CMD_COUNT_LSB];

  // ***********************************************
  // Next-state logic
  // ***********************************************
  always_comb begin
    logic refuse;
    logic guarded;
    refuse = 1'b0;
    guarded = s.write_lock[sec] ||
      bp_hit(s.block_protect_bits, s.top_bottom_select, sec); // [R09] [R17]
    next_s = s;
    arr_we = 1'b0;
    arr_and = 1'b0;
    arr_otp = 1'b0;
    arr_addr = s.addr;
    arr_wdata = s.data;

    // Power-up hold-off timer
    if (!s.por_done) begin
      if (s.por_cnt == sfp_pkg::POR_CYCLES - 16'h0001) begin
        next_s.por_done = 1'b1; // [R08]
      end else begin
        next_s.por_cnt = s.por_cnt + 16'h0001;
      end
    end

    // Register reads, answered next cycle
    next_s.rdata = '0;
    if (rd_in) begin
      unique case (addr_in)
        sfp_pkg::REG_STATUS: next_s.rdata = {23'h0, s.refused, s.por_done,
          s.top_bottom_select, s.block_protect_bits, s.wel, s.busy};
        sfp_pkg::REG_ADDR: next_s.rdata = {8'h00, s.addr};
        sfp_pkg::REG_DATA: next_s.rdata = {24'h0, s.rd_byte};
        sfp_pkg::REG_LOCK: next_s.rdata = {30'h0, s.lock_down[sec], s.write_lock[sec]};
        default: next_s.rdata = '0;
      endcase
    end

    // Plain register writes
    if (wr_in && addr_in == sfp_pkg::REG_ADDR) begin
      next_s.addr = wdata_in[23:0];
    end
    if (wr_in && addr_in == sfp_pkg::REG_DATA) begin
      next_s.data = wdata_in[7:0];
    end
    if (wr_in && addr_in == sfp_pkg::REG_STATUS && wdata_in[sfp_pkg::STAT_REFUSED_BIT]) begin
      next_s.refused = 1'b0;
    end

    // Command sequencing
    unique case (s.state)
      sfp_pkg::ST_IDLE: begin
        if (cmd_wr && is_modify(op)) begin
          if (!s.por_done || clk_count[2:0] != 3'h0 || !s.wel) begin
            refuse = 1'b1; // [R06] [R07] [R08]
          end else begin
            next_s.wel = 1'b0;
            unique case (op)
              sfp_pkg::CMD_PROGRAM: begin
                if (guarded) begin
                  refuse = 1'b1; // [R17]
                end else begin
                  arr_we = 1'b1;
                  arr_and = 1'b1; // [R01]
                end
              end
              sfp_pkg::CMD_OTP_PROGRAM: begin
                arr_we = 1'b1;
                arr_and = 1'b1;
                arr_otp = 1'b1; // [R05]
              end
              sfp_pkg::CMD_SUB_ERASE: begin
                if (guarded) begin
                  refuse = 1'b1; // [R17]
                end else begin
                  next_s.state = sfp_pkg::ST_ERASE; // [R03] [R16]
                  next_s.cursor = {s.addr[23:sfp_pkg::SUB_LSB], 12'h000};
                  next_s.last = {s.addr[23:sfp_pkg::SUB_LSB], 12'hfff};
                end
              end
              sfp_pkg::CMD_SEC_ERASE: begin
                if (guarded) begin
                  refuse = 1'b1; // [R17]
                end else begin
                  next_s.state = sfp_pkg::ST_ERASE; // [R03]
                  next_s.cursor = {sec, 16'h0000};
                  next_s.last = {sec, 16'hffff};
                end
              end
              sfp_pkg::CMD_BULK_ERASE: begin
                if (|s.write_lock || s.block_protect_bits != 4'h0) begin
                  refuse = 1'b1; // [R09] [R17]
                end else begin
                  next_s.state = sfp_pkg::ST_ERASE; // [R03]
                  next_s.cursor = 24'h000000;
                  next_s.last = 24'hffffff;
                end
              end
              sfp_pkg::CMD_WR_STATUS: begin
                if (!wp_b_in && !quad_mode_in) begin
                  refuse = 1'b1; // [R15]
                end else begin
                  next_s.block_protect_bits = s.data[3:0];
                  next_s.top_bottom_select = s.data[4];
                end
              end
              sfp_pkg::CMD_WR_LOCK: begin
                if (s.lock_down[sec]) begin
                  refuse = 1'b1; // [R10] [R11]
                end else begin
                  next_s.write_lock[sec] = s.data[0]; // [R09]
                  next_s.lock_down[sec] = s.data[1];
                end
              end
              default: refuse = 1'b1;
            endcase
          end
        end else if (cmd_wr) begin
          unique case (op)
            sfp_pkg::CMD_WR_ENABLE: next_s.wel = 1'b1; // [R07]
            sfp_pkg::CMD_WR_DISABLE: next_s.wel = 1'b0;
            sfp_pkg::CMD_READ, sfp_pkg::CMD_OTP_READ: begin
              next_s.state = sfp_pkg::ST_READ;
              next_s.rd_otp = (op == sfp_pkg::CMD_OTP_READ);
              arr_otp = (op == sfp_pkg::CMD_OTP_READ); // [R05] Registered read picks store now
            end
            default: next_s.wel = s.wel;
          endcase
        end
      end
      sfp_pkg::ST_ERASE: begin
        arr_we = 1'b1;
        arr_addr = s.cursor;
        arr_wdata = sfp_pkg::ERASED_BYTE; // [R02]
        refuse = cmd_wr;
        if (s.cursor == s.last) begin
          next_s.state = sfp_pkg::ST_IDLE;
        end else begin
          next_s.cursor = s.cursor + 24'h000001;
        end
      end
      sfp_pkg::ST_READ: begin
        arr_otp = s.rd_otp;
        next_s.rd_byte = arr_rdata;
        next_s.state = sfp_pkg::ST_IDLE;
        refuse = cmd_wr;
      end
      default: next_s.state = sfp_pkg::ST_IDLE;
    endcase

    // Refusal flag: a new refusal wins over a clear
    if (refuse) begin
      next_s.refused = 1'b1;
    end
    next_s.busy = (next_s.state != sfp_pkg::ST_IDLE);
  end

  // ***********************************************
  // State register
  // ***********************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
      s.write_lock <= '1; // [R12]
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign busy_out = s.busy;

  // Main and one-time storage
  sfp_array #(
    .ADDR_W(sfp_pkg::ADDR_W)
  ) u_array (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(arr_we),
    .wr_and_in(arr_and),
    .otp_sel_in(arr_otp),
    .addr_in(arr_addr),
    .wdata_in(arr_wdata),
    .rdata_out(arr_rdata)
  );

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  AST_ERASE_ONES: assert property ( // [R02]
    arr_we && !arr_and |-> arr_wdata == 8'hff)
    else $error("erase wrote a byte other than all ones");
  AST_ERASE_SPAN: assert property ( // [R03]
    s.state == sfp_pkg::ST_ERASE && s.last != 24'hffffff |->
      s.last[11:0] == 12'hfff && s.cursor[23:16] == s.last[23:16] &&
      (s.last[15:12] == 4'hf || s.cursor[23:12] == s.last[23:12]))
    else $error("erase walked outside a subsector or sector");
  AST_WHOLE_BYTES: assert property ( // [R06]
    cmd_wr && is_modify(op) && clk_count[2:0] != 3'h0 |->
      (s.state != sfp_pkg::ST_IDLE || !arr_we) ##1 s.refused)
    else $error("partial-byte command was executed");
  AST_NEED_WEL: assert property ( // [R07]
    s.state == sfp_pkg::ST_IDLE && arr_we |-> s.wel ##1 !s.wel)
    else $error("array changed without write enable");
  AST_POR_HOLD: assert property ( // [R08]
    !s.por_done |-> !arr_we && &s.write_lock)
    else $error("change during power-up hold-off");
  AST_LOCKED_SECTOR: assert property ( // [R09]
    arr_we && !arr_otp |-> !s.write_lock[arr_addr[23:16]])
    else $error("write reached a locked sector");
  AST_LOCK_FROZEN: assert property ( // [R10]
    |s.lock_down |=> ($past(s.lock_down) & ~s.lock_down) == '0 &&
      (($past(s.write_lock) ^ s.write_lock) & $past(s.lock_down)) == '0)
    else $error("locked-down sector changed its lock");
  AST_LOCK_WR_IGNORED: assert property ( // [R11]
    s.state == sfp_pkg::ST_IDLE && cmd_wr && op == sfp_pkg::CMD_WR_LOCK &&
      s.lock_down[sec] |=> s.refused)
    else $error("lock write accepted while locked down");
  AST_BP_AREA: assert property ( // [R13]
    arr_we && !arr_otp |->
      !bp_hit(s.block_protect_bits, s.top_bottom_select, arr_addr[23:16]))
    else $error("write reached the block-protect area");

endmodule

`default_nettype wire

// file: inc/sfp_pkg.sv
// Purpose: Shared constants and types for the flash array protection block
// Assumes: 20 MHz system clock, 24-bit byte addresses
// Notes: Register offsets are byte addresses on the plain register port

package sfp_pkg;

  // ***********************************************
  // Array geometry
  // ***********************************************
  localparam int ADDR_W = 24;
  localparam int SECTORS = 256;
  localparam int OTP_BYTES = 64;
  localparam int SEC_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_LOCK = 8'h10;
  localparam int STAT_REFUSED_BIT = 8;
  localparam int CMD_COUNT_LSB = 16;

  // ***********************************************
  // Power-up hold-off
  // ***********************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS = 1000;
  localparam logic [15:0] POR_CYCLES =
    16'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ***********************************************
  // Commands and states
  // ***********************************************
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_WR_ENABLE = 4'h1,
    CMD_WR_DISABLE = 4'h2,
    CMD_PROGRAM = 4'h3,
    CMD_SUB_ERASE = 4'h4,
    CMD_SEC_ERASE = 4'h5,
    CMD_BULK_ERASE = 4'h6,
    CMD_WR_STATUS = 4'h7,
    CMD_WR_LOCK = 4'h8,
    CMD_READ = 4'h9,
    CMD_OTP_PROGRAM = 4'ha,
    CMD_OTP_READ = 4'hb
  } sfp_cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_READ = 2'b10
  } sfp_state_e;

endpackage

// file: rtl/sfp_array.sv
// Purpose: Byte-wide main flash array plus separate one-time area
// Assumes: One access per clock, read data registered
// Notes: Program ANDs into the stored byte, erase overwrites

`timescale 1ns/1ps
`default_nettype none

module sfp_array #(
  parameter int ADDR_W = 24
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic wr_and_in,
  input wire logic otp_sel_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  typedef struct packed {
    logic [7:0] rdata;
  } sfp_array_s;

  if (ADDR_W < sfp_pkg::SEC_LSB + 1 || ADDR_W > sfp_pkg::ADDR_W) begin : g_chk
    $error("sfp_array: unsupported address width");
  end

  // ***********************************************
  // Storage
  // ***********************************************
  logic [7:0] mem [0:(2**ADDR_W)-1]; // [R04]
  logic [7:0] otp [0:sfp_pkg::OTP_BYTES-1]; // [R05]
  logic [5:0] otp_addr;
  logic [7:0] cur_byte;
  sfp_array_s s, next_s;

  assign otp_addr = addr_in[5:0];
  assign cur_byte = otp_sel_in ? otp[otp_addr] : mem[addr_in];

  // Writes: program clears bits only, erase sets the byte
  always_ff @(posedge mclk_in) begin
    if (wr_en_in && otp_sel_in) begin
      otp[otp_addr] <= cur_byte & wdata_in; // [R01]
    end else if (wr_en_in) begin
      mem[addr_in] <= wr_and_in ? (cur_byte & wdata_in) : wdata_in; // [R01]
    end
  end

  // Registered read of the addressed byte
  always_comb begin
    next_s = s;
    next_s.rdata = cur_byte;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;

  AST_ONE_WAY: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R01]
    wr_en_in && wr_and_in && !otp_sel_in |=>
      mem[$past(addr_in)] == ($past(cur_byte) & $past(wdata_in)))
    else $error("program set a bit that was zero");

endmodule

`default_nettype wire

// file: test/sfp_host.sv
// Purpose: Register bus master standing in for the serial host
// Assumes: Strobes start by NBA just after a rising edge
// Notes: A modify command sent through modify goes out after a write enable, one sent through cmd does not

`timescale 1ns/1ps
`default_nettype none

module sfp_host (
  input wire logic mclk_in,
  input wire logic [31:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // ****************
  // Bus cycles
  // ****************
  // Idle bus from time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0000_0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
  endtask

  // One read strobe, data taken in the cycle after
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask

  // Serial command with its clock-pulse count
  task automatic cmd(input logic [3:0] op, input logic [15:0] cnt);
    wr_reg(sfp_pkg::REG_CMD, {cnt, 12'h000, op});
  endtask

  // Modify command preceded by write enable
  task automatic modify(input logic [3:0] op, input logic [15:0] cnt);
    cmd(sfp_pkg::CMD_WR_ENABLE, 16'h0008);
    cmd(op, cnt);
  endtask
endmodule

`default_nettype wire

// file: test/test_serial_flash_array_protection.sv
// Purpose: Self-checking bench for the flash protection guard
// Assumes: 20 MHz clock, host model drives the register port
// Notes: Erases stay at subsector size to keep the run short

`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_array_protection;
  logic mclk_in;
  logic rst_b_in;
  logic wp_b_in;
  logic quad_mode_in;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic busy;
  logic [31:0] r;
  int mismatches;
  int n_tests;
  int nb;
  int sz;
  typedef struct {logic tb; logic [3:0] code; logic [7:0] sec; logic exp;} sfp_row_s;
  sfp_row_s rows[64];

  sfp_guard u_sfp_guard (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .wp_b_in(wp_b_in),
    .quad_mode_in(quad_mode_in), .rdata_out(rdata), .busy_out(busy));
  sfp_host u_sfp_host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // Clock at 50 ns
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // ****************
  // Compare and helpers
  // ****************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rdr(input logic [7:0] a);
    u_sfp_host.rd_reg(a, r);
  endtask

  task automatic setad(input logic [23:0] a, input logic [7:0] d);
    u_sfp_host.wr_reg(sfp_pkg::REG_ADDR, {8'h00, a});
    u_sfp_host.wr_reg(sfp_pkg::REG_DATA, {24'h0, d});
  endtask

  // Count busy cycles following a command
  task automatic wait_busy();
    nb = 0;
    #1;
    while (busy === 1'b1 && nb < 70000) begin
      nb++;
      @(posedge mclk_in);
      #1;
    end
  endtask

  // Compare the refused flag, then clear it
  task automatic refused(input logic exp);
    rdr(sfp_pkg::REG_STATUS);
    check_word({31'h0, r[sfp_pkg::STAT_REFUSED_BIT]}, {31'h0, exp});
    u_sfp_host.wr_reg(sfp_pkg::REG_STATUS, 32'h0000_0100);
  endtask

  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    setad(a, d);
    u_sfp_host.modify(sfp_pkg::CMD_PROGRAM, 16'h0028);
  endtask

  task automatic lock(input logic [7:0] s, input logic [7:0] d);
    setad({s, 16'h0000}, d);
    u_sfp_host.modify(sfp_pkg::CMD_WR_LOCK, 16'h0010);
  endtask

  task automatic wstat(input logic t, input logic [3:0] c);
    setad(24'h0, {3'h0, t, c});
    u_sfp_host.modify(sfp_pkg::CMD_WR_STATUS, 16'h0010);
  endtask

  // Array byte through a read command
  task automatic rbyte(input logic [23:0] a, input logic [7:0] exp);
    setad(a, 8'h00);
    u_sfp_host.cmd(sfp_pkg::CMD_READ, 16'h0020);
    wait_busy();
    rdr(sfp_pkg::REG_DATA);
    check_word(r, {24'h0, exp});
  endtask

  // Sectors covered by a protect code
  function automatic int psize(input logic [3:0] c);
    return (c == 4'h0) ? 0 : (c > 4'h8) ? 256 : (1 << (c - 4'h1));
  endfunction

  // Hang guard
  initial begin
    #(30000 * 50);
    mismatches++;
    complete_run();
  end

  // ****************
  // Stimulus
  // ****************
  initial begin
    rst_b_in = 1'b0;
    wp_b_in = 1'b1;
    quad_mode_in = 1'b0;
    mismatches = 0;
    n_tests = 0;
    for (int i = 0; i < 64; i++) begin
      sz = psize(4'(i >> 1));
      rows[i].tb = i[5];
      rows[i].code = 4'(i >> 1);
      rows[i].sec = 8'(i[5] ? sz - 1 + i[0] : 256 - sz - i[0]);
      rows[i].exp = i[5] ? (int'(rows[i].sec) < sz) : (int'(rows[i].sec) >= 256 - sz);
    end
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    prog(24'h000000, 8'h00);
    rdr(sfp_pkg::REG_STATUS);
    check_word(r & 32'h0000_0180, 32'h0000_0100);
    u_sfp_host.wr_reg(sfp_pkg::REG_STATUS, 32'h0000_0100);
    rdr(sfp_pkg::REG_LOCK);
    check_word(r, 32'h0000_0001);
    repeat (sfp_pkg::POR_CYCLES) @(posedge mclk_in);
    u_sfp_host.cmd(sfp_pkg::CMD_WR_DISABLE, 16'h0008);
    rdr(sfp_pkg::REG_STATUS);
    check_word(r, 32'h0000_0080);
    rdr(8'h14);
    check_word(r, 32'h0);
    u_sfp_host.modify(sfp_pkg::CMD_BULK_ERASE, 16'h0008);
    refused(1'b1);
    setad(24'h030000, 8'h00);
    u_sfp_host.modify(sfp_pkg::CMD_SEC_ERASE, 16'h0020);
    refused(1'b1);
    lock(8'h00, 8'h00);
    rdr(sfp_pkg::REG_LOCK);
    check_word(r, 32'h0);
    setad(24'h000100, 8'h00);
    u_sfp_host.modify(sfp_pkg::CMD_SUB_ERASE, 16'h0020);
    wait_busy();
    check_word(nb, 32'd4096);
    refused(1'b0);
    rbyte(24'h000fff, 8'hff);
    rbyte(24'h000000, 8'hff);
    prog(24'h000fff, 8'hf0);
    rbyte(24'h000fff, 8'hf0);
    prog(24'h000fff, 8'h3c);
    rbyte(24'h000fff, 8'h30);
    setad(24'h000fff, 8'h00);
    u_sfp_host.cmd(sfp_pkg::CMD_PROGRAM, 16'h0028);
    refused(1'b1);
    rbyte(24'h000fff, 8'h30);
    setad(24'h000fff, 8'h00);
    u_sfp_host.modify(sfp_pkg::CMD_PROGRAM, 16'h0029);
    refused(1'b1);
    rbyte(24'h000fff, 8'h30);
    setad(24'h00003f, 8'h00);
    u_sfp_host.modify(sfp_pkg::CMD_OTP_PROGRAM, 16'h0028);
    u_sfp_host.cmd(sfp_pkg::CMD_OTP_READ, 16'h0020);
    wait_busy();
    rdr(sfp_pkg::REG_DATA);
    check_word(r, 32'h0);
    rbyte(24'h000fff, 8'h30);
    lock(8'h00, 8'h01);
    prog(24'h000fff, 8'h00);
    refused(1'b1);
    rbyte(24'h000fff, 8'h30);
    for (int s = 0; s < 256; s++) begin
      lock(8'(s), 8'h00);
    end
    // Protect code table at both selector values
    foreach (rows[i]) begin
      wstat(rows[i].tb, rows[i].code);
      rdr(sfp_pkg::REG_STATUS);
      check_word(r, {24'h0, 1'b1, rows[i].tb, rows[i].code, 2'b00});
      // Zero data keeps a never-erased byte defined
      prog({rows[i].sec, 16'h0000}, 8'h00);
      refused(rows[i].exp);
    end
    // Pin low in single mode freezes the code, quad mode does not
    wstat(1'b0, 4'h8);
    @(posedge mclk_in);
    wp_b_in <= 1'b0;
    wstat(1'b0, 4'h0);
    refused(1'b1);
    rdr(sfp_pkg::REG_STATUS);
    check_word(r, 32'h0000_00a0);
    @(posedge mclk_in);
    quad_mode_in <= 1'b1;
    wstat(1'b0, 4'h0);
    refused(1'b0);
    @(posedge mclk_in);
    wp_b_in <= 1'b1;
    quad_mode_in <= 1'b0;
    lock(8'h02, 8'h03);
    rdr(sfp_pkg::REG_LOCK);
    check_word(r, 32'h0000_0003);
    lock(8'h02, 8'h00);
    refused(1'b1);
    rdr(sfp_pkg::REG_LOCK);
    check_word(r, 32'h0000_0003);
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    setad(24'h020000, 8'h00);
    rdr(sfp_pkg::REG_LOCK);
    check_word(r, 32'h0000_0001);
    rdr(sfp_pkg::REG_STATUS);
    check_word(r, 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire
